/* tccp_pin_partner.sv */
// Pin partner: capture pulse source, external count clock, output pin load.
// Assumes the bench calls its tasks; sys_clk is the block clock.
`timescale 1ns/1ps
`default_nettype none
module tccp_pin_partner (
   // Clock
   input wire logic sys_clk,
   // Pins
   output var logic external_irq_pin,
   output var logic ext_count_pin,
   input wire logic match_toggle_pin
);
   // Both driven lines idle low, so every pulse gives one rise and one fall
   initial begin
      external_irq_pin = 1'b0;
      ext_count_pin = 1'b0;
   end
   task automatic pulses(input int n, input int hi, input int lo);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk) external_irq_pin <= 1'b1;
         repeat (hi) @(posedge sys_clk);
         external_irq_pin <= 1'b0;
         repeat (lo - 1) @(posedge sys_clk);
      end
   endtask : pulses
   task automatic ext_clocks(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge sys_clk);
         ext_count_pin <= 1'b1;
         repeat (half) @(posedge sys_clk);
         ext_count_pin <= 1'b0;
      end
   endtask : ext_clocks
   // Cycles the pin stays at v, capped so a stuck pin cannot hang
   task automatic run_len(input logic v, input int lim, output int n);
      n = 0;
      while (match_toggle_pin === v && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
   endtask : run_len
   // Two periods are dropped first, the first possibly partial: they may still carry old settings
   task automatic measure(output int hi, output int lo);
      int s;
      repeat (2) begin
         run_len(1'b1, 20000, s);
         run_len(1'b0, 20000, s);
      end
      run_len(1'b1, 20000, hi);
      run_len(1'b0, 20000, lo);
   endtask : measure
endmodule : tccp_pin_partner
`default_nettype wire

/* tccp_pkg.sv */
// Package for the paired timer with capture, compare toggle and PWM.
// Assumes a plain address/strobe register port and a 200 MHz system clock.
package tccp_pkg;
   // Register indices on the plain port
   localparam logic [3:0] ADDR_MODE0 = 4'h0;
   localparam logic [3:0] ADDR_MODE1 = 4'h1;
   localparam logic [3:0] ADDR_DATA0 = 4'h2;
   localparam logic [3:0] ADDR_DATA1 = 4'h3;
   localparam logic [3:0] ADDR_PERIOD = 4'h4;
   localparam logic [3:0] ADDR_DUTY = 4'h5;
   localparam logic [3:0] ADDR_HIGH = 4'h6;
   localparam logic [3:0] ADDR_PORTFN = 4'h7;
   localparam logic [3:0] ADDR_EDGE = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'h9;
   // Mode 0 fields
   localparam int M0_CLK_LSB = 0;
   localparam int M0_CAP = 3;
   // Mode 1 fields
   localparam int M1_CLK_LSB = 0;
   localparam int M1_JOIN = 2;
   localparam int M1_CAP = 3;
   localparam int M1_PULSE_MOD_ENABLE = 4;
   localparam int M1_POL = 5;
   // Port function fields
   localparam int PF_COMPARE = 0;
   localparam int PF_PWMPIN = 1;
   // High register fields
   localparam int HI_PER_LSB = 2;
   localparam int HI_DUTY_LSB = 0;
   // Status bits
   localparam int ST_T0 = 0;
   localparam int ST_T1 = 1;
   localparam int ST_CAP = 2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Clocking: figures at an 8 MHz reference, converted to system cycles
   localparam int SYS_NS = 5;
   localparam int PWM_NS00 = 125;
   localparam int PWM_NS01 = 250;
   localparam int PWM_NS10 = 1000;
   localparam int PWM_CYC00 = PWM_NS00 / SYS_NS;
   localparam int PWM_CYC01 = PWM_NS01 / SYS_NS;
   localparam int PWM_CYC10 = PWM_NS10 / SYS_NS;
   // Timer 0 prescale exponents for codes 0..6 (code 7 is external clock)
   localparam logic [15:0] T0_SHIFTS = 16'h0000;
   localparam logic [1:0] CLK_EXT_T1 = 2'h3;
   localparam logic [2:0] CLK_EXT_T0 = 3'h7;
   // Edge select codes
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;

   typedef enum logic [1:0] {
      TCCP_SPLIT = 2'b00,
      TCCP_JOINED = 2'b01,
      TCCP_PULSE = 2'b10
   } tccp_mode_e;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tccp_bus_s;

   // Cycle count for one prescaled tick of Timer 0
   function automatic logic [11:0] tccp_t0_div(input logic [2:0] code);
      unique case (code)
         3'h0: tccp_t0_div = 12'h002;
         3'h1: tccp_t0_div = 12'h004;
         3'h2: tccp_t0_div = 12'h008;
         3'h3: tccp_t0_div = 12'h020;
         3'h4: tccp_t0_div = 12'h080;
         3'h5: tccp_t0_div = 12'h200;
         default: tccp_t0_div = 12'h800;
      endcase
   endfunction : tccp_t0_div

   // Cycle count for one prescaled tick of Timer 1 and the PWM
   function automatic logic [11:0] tccp_t1_div(input logic [1:0] code);
      unique case (code)
         2'h0: tccp_t1_div = 12'(PWM_CYC00);
         2'h1: tccp_t1_div = 12'(PWM_CYC01);
         default: tccp_t1_div = 12'(PWM_CYC10);
      endcase
   endfunction : tccp_t1_div
endpackage : tccp_pkg

/* tccp_timer.sv */
// Paired 8-bit timer with joined 16-bit mode, capture, compare toggle and 10-bit PWM.
// Assumes a register port in the sys_clk domain and asynchronous pins for the
// capture input and the external count clock.
`timescale 1ns/1ps
`default_nettype none
module tccp_timer
   import tccp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Register port
   input wire tccp_pkg::tccp_bus_s bus,
   output logic [7:0] rdata,
   // Pins
   input wire logic external_irq_pin,
   input wire logic ext_count_pin,
   output logic match_toggle_pin,
   // Interrupt requests, one-cycle pulses
   output logic timer0_irq,
   output logic timer1_irq,
   output logic capture_irq
);
   import tccp_pkg::*;

   logic [7:0] timer0_mode_reg, timer1_mode_reg, port_b_function_reg;
   logic [7:0] timer0_match_value, timer1_match_value;
   logic [7:0] pulse_period_low, pulse_duty_low, pulse_high_bits;
   logic [1:0] irq_edge_select;
   logic [7:0] timer0_count, timer1_count, timer0_snapshot, timer1_snapshot;
   logic [2:0] sticky_q;
   logic [9:0] duty_slave_q, pwm_cnt_q;
   logic pwm_q, toggle_q;
   logic [11:0] div0_q, div1_q;
   logic [1:0] cap_sync_q, ext_sync_q;
   logic cap_prev_q, ext_prev_q;

   logic join_w, timer0_snapshot_select_w, timer1_snapshot_select_w, pulse_mod_enable_w, pol_w;
   assign join_w = timer1_mode_reg[M1_JOIN];
   assign timer0_snapshot_select_w = timer0_mode_reg[M0_CAP];
   assign timer1_snapshot_select_w = timer1_mode_reg[M1_CAP];
   assign pulse_mod_enable_w = timer1_mode_reg[M1_PULSE_MOD_ENABLE];
   assign pol_w = timer1_mode_reg[M1_POL];
   logic [2:0] clk0_w;
   logic [1:0] clk1_w;
   assign clk0_w = timer0_mode_reg[M0_CLK_LSB +: 3];
   assign clk1_w = timer1_mode_reg[M1_CLK_LSB +: 2];

   tccp_mode_e mode_w;
   always_comb begin
      if (join_w && clk1_w == CLK_EXT_T1) begin
         mode_w = TCCP_JOINED;
      end else if (!join_w && pulse_mod_enable_w) begin
         mode_w = TCCP_PULSE;
      end else begin
         mode_w = TCCP_SPLIT;
      end
   end

   // Pin synchronisers; first stage read only by the second
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cap_sync_q <= 2'h0;
         ext_sync_q <= 2'h0;
         cap_prev_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         cap_sync_q <= {cap_sync_q[0], external_irq_pin};
         ext_sync_q <= {ext_sync_q[0], ext_count_pin};
         cap_prev_q <= cap_sync_q[1];
         ext_prev_q <= ext_sync_q[1];
      end
   end

   logic rise_w, fall_w, edge_w, ext_tick_w;
   assign rise_w = cap_sync_q[1] & ~cap_prev_q;
   assign fall_w = ~cap_sync_q[1] & cap_prev_q;
   assign edge_w = (irq_edge_select == EDGE_FALL && fall_w) ||
                   (irq_edge_select == EDGE_RISE && rise_w) ||
                   (irq_edge_select == EDGE_BOTH && (rise_w || fall_w));
   assign ext_tick_w = ext_sync_q[1] & ~ext_prev_q;

   // Prescalers; the joined count uses the Timer 0 source
   logic tick0_w, tick1_w;
   assign tick0_w = (clk0_w == CLK_EXT_T0) ? ext_tick_w : (div0_q == 12'h000);
   assign tick1_w = (div1_q == 12'h000);
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div0_q <= 12'h000;
         div1_q <= 12'h000;
      end else begin
         div0_q <= (div0_q == 12'h000) ? tccp_t0_div(clk0_w) - 12'h001 : div0_q - 12'h001;
         div1_q <= (div1_q == 12'h000) ? tccp_t1_div(clk1_w) - 12'h001 : div1_q - 12'h001;
      end
   end

   // Counters, match and capture
   logic [15:0] cnt16_w, match16_w;
   logic match0_w, match1_w, match16_hit_w, timer0_snapshot_select_ev_w, timer1_snapshot_select_ev_w, cap16_ev_w;
   assign cnt16_w = {timer1_count, timer0_count};
   assign match16_w = {timer1_match_value, timer0_match_value};
   assign match16_hit_w = mode_w == TCCP_JOINED && tick0_w && cnt16_w == match16_w;
   assign match0_w = mode_w != TCCP_JOINED && tick0_w && timer0_count == timer0_match_value;
   assign match1_w = mode_w == TCCP_SPLIT && tick1_w && timer1_count == timer1_match_value;
   assign cap16_ev_w = mode_w == TCCP_JOINED && timer0_snapshot_select_w && edge_w;
   assign timer0_snapshot_select_ev_w = mode_w != TCCP_JOINED && timer0_snapshot_select_w && edge_w;
   assign timer1_snapshot_select_ev_w = mode_w == TCCP_SPLIT && timer1_snapshot_select_w && edge_w;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer0_count <= RESET_BYTE;
         timer1_count <= RESET_BYTE;
      end else if (cap16_ev_w || match16_hit_w) begin
         {timer1_count, timer0_count} <= 16'h0000;
      end else if (mode_w == TCCP_JOINED) begin
         if (tick0_w) begin
            {timer1_count, timer0_count} <= cnt16_w + 16'h0001;
         end
      end else begin
         if (timer0_snapshot_select_ev_w || match0_w) begin
            timer0_count <= RESET_BYTE;
         end else if (tick0_w) begin
            timer0_count <= timer0_count + 8'h01;
         end
         if (timer1_snapshot_select_ev_w || match1_w || mode_w == TCCP_PULSE) begin
            timer1_count <= RESET_BYTE;
         end else if (tick1_w) begin
            timer1_count <= timer1_count + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer0_snapshot <= RESET_BYTE;
         timer1_snapshot <= RESET_BYTE;
      end else if (cap16_ev_w) begin
         {timer1_snapshot, timer0_snapshot} <= cnt16_w;
      end else begin
         if (timer0_snapshot_select_ev_w) begin
            timer0_snapshot <= timer0_count;
         end
         if (timer1_snapshot_select_ev_w) begin
            timer1_snapshot <= timer1_count;
         end
      end
   end

   // Interrupt pulses; a match in the capture cycle still fires
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer0_irq <= 1'b0;
         timer1_irq <= 1'b0;
         capture_irq <= 1'b0;
      end else begin
         timer0_irq <= match0_w || match16_hit_w;
         timer1_irq <= match1_w;
         capture_irq <= edge_w;
      end
   end

   // Compare toggle on the Timer 1 match, or joined match in 16-bit mode
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         toggle_q <= 1'b0;
      end else if (match1_w || match16_hit_w) begin
         toggle_q <= ~toggle_q;
      end
   end

   // PWM: counter runs 1..period, so one period is exactly period ticks; duty slave loads at the period match
   logic [9:0] period_w, duty_master_w;
   logic pwm_end_w;
   assign period_w = {pulse_high_bits[HI_PER_LSB +: 2], pulse_period_low};
   assign duty_master_w = {pulse_high_bits[HI_DUTY_LSB +: 2], pulse_duty_low};
   assign pwm_end_w = pwm_cnt_q == period_w;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pwm_cnt_q <= 10'h000;
         duty_slave_q <= 10'h000;
      end else if (mode_w != TCCP_PULSE) begin
         pwm_cnt_q <= 10'h001;
         duty_slave_q <= duty_master_w;
      end else if (tick1_w) begin
         if (pwm_end_w) begin
            pwm_cnt_q <= 10'h001;
            duty_slave_q <= duty_master_w;
         end else begin
            pwm_cnt_q <= pwm_cnt_q + 10'h001;
         end
      end
   end

   // Duty level lasts duty ticks; duty=period stays active, zero stays inactive
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pwm_q <= 1'b0;
      end else if (duty_slave_q == period_w) begin
         pwm_q <= pol_w;
      end else begin
         pwm_q <= (pwm_cnt_q <= duty_slave_q) ? pol_w : ~pol_w;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         match_toggle_pin <= 1'b0;
      end else if (mode_w == TCCP_PULSE && port_b_function_reg[PF_PWMPIN]) begin
         match_toggle_pin <= pwm_q;
      end else if (port_b_function_reg[PF_COMPARE]) begin
         match_toggle_pin <= toggle_q;
      end else begin
         match_toggle_pin <= 1'b0;
      end
   end

   // Register writes; writes to the shared address only load the match value
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer0_mode_reg <= RESET_BYTE;
         timer1_mode_reg <= RESET_BYTE;
         timer0_match_value <= 8'hff;
         timer1_match_value <= 8'hff;
         pulse_period_low <= RESET_BYTE;
         pulse_duty_low <= RESET_BYTE;
         pulse_high_bits <= RESET_BYTE;
         port_b_function_reg <= RESET_BYTE;
         irq_edge_select <= 2'h0;
      end else if (bus.wr) begin
         unique case (bus.addr)
            ADDR_MODE0: timer0_mode_reg <= bus.wdata;
            ADDR_MODE1: timer1_mode_reg <= bus.wdata;
            ADDR_DATA0: timer0_match_value <= bus.wdata;
            ADDR_DATA1: timer1_match_value <= bus.wdata;
            ADDR_PERIOD: pulse_period_low <= bus.wdata;
            ADDR_DUTY: pulse_duty_low <= bus.wdata;
            ADDR_HIGH: pulse_high_bits <= {4'h0, bus.wdata[3:0]};
            ADDR_PORTFN: port_b_function_reg <= {6'h00, bus.wdata[1:0]};
            ADDR_EDGE: irq_edge_select <= bus.wdata[1:0];
            default: ;
         endcase
      end
   end

   // Sticky status, set wins over a clear-by-write-one
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sticky_q <= 3'h0;
      end else begin
         sticky_q <= (sticky_q & ~((bus.wr && bus.addr == ADDR_STATUS) ? bus.wdata[2:0] : 3'h0))
                     | {edge_w, match1_w, match0_w || match16_hit_w};
      end
   end

   // Read data registered one cycle after the strobe
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            ADDR_MODE0: rdata <= timer0_mode_reg;
            ADDR_MODE1: rdata <= timer1_mode_reg;
            ADDR_DATA0: rdata <= timer0_snapshot_select_w ? timer0_snapshot : timer0_count;
            ADDR_DATA1: rdata <= (timer1_snapshot_select_w || (timer0_snapshot_select_w && join_w)) ? timer1_snapshot : timer1_count;
            ADDR_PERIOD: rdata <= pulse_period_low;
            ADDR_DUTY: rdata <= pulse_duty_low;
            ADDR_HIGH: rdata <= pulse_high_bits;
            ADDR_PORTFN: rdata <= port_b_function_reg;
            ADDR_EDGE: rdata <= {6'h00, irq_edge_select};
            ADDR_STATUS: rdata <= {5'h00, sticky_q};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   property p_capture_clears;
      @(posedge sys_clk) disable iff (!arst_n) timer0_snapshot_select_ev_w |=> timer0_count == 8'h00 && timer0_snapshot == $past(timer0_count);
   endproperty
   a_capture_clears: assert property (p_capture_clears) else $error("capture did not store and clear");
   property p_capture_irq;
      @(posedge sys_clk) disable iff (!arst_n) edge_w |=> capture_irq;
   endproperty
   a_capture_irq: assert property (p_capture_irq) else $error("edge gave no interrupt");
   property p_match_irq;
      @(posedge sys_clk) disable iff (!arst_n) (match0_w && timer0_snapshot_select_ev_w) |=> timer0_irq && sticky_q[ST_T0];
   endproperty
   a_match_irq: assert property (p_match_irq) else $error("match lost beside capture");
   property p_toggle;
      @(posedge sys_clk) disable iff (!arst_n) match1_w |=> toggle_q != $past(toggle_q);
   endproperty
   a_toggle: assert property (p_toggle) else $error("compare did not toggle");
   property p_join_irq;
      @(posedge sys_clk) disable iff (!arst_n) match16_hit_w |=> timer0_irq && !timer1_irq && cnt16_w == 16'h0000;
   endproperty
   a_join_irq: assert property (p_join_irq) else $error("joined match wrong");
   property p_duty_load;
      @(posedge sys_clk) disable iff (!arst_n) (mode_w == TCCP_PULSE && !pwm_end_w) |=> $stable(duty_slave_q);
   endproperty
   a_duty_load: assert property (p_duty_load) else $error("duty changed mid period");
   property p_pol_full;
      @(posedge sys_clk) disable iff (!arst_n) (duty_slave_q == period_w) |=> pwm_q == $past(pol_w);
   endproperty
   a_pol_full: assert property (p_pol_full) else $error("full duty level wrong");
   property p_pin_pwm;
      @(posedge sys_clk) disable iff (!arst_n)
         (mode_w == TCCP_PULSE && port_b_function_reg[PF_PWMPIN]) |=> match_toggle_pin == $past(pwm_q);
   endproperty
   a_pin_pwm: assert property (p_pin_pwm) else $error("pin not following PWM");
endmodule : tccp_timer
`default_nettype wire

/* tccp_timer_tb_top.sv */
// Self-checking bench for the paired timer with capture, compare and PWM.
// Assumes the package offsets and a 200 MHz sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tccp_timer_tb_top import tccp_pkg::*;;
   localparam int WATCH_CYC = 90000;
   logic sys_clk = 1'b0;
   logic arst_n;
   tccp_bus_s bus;
   logic [7:0] rdata;
   logic external_irq_pin;
   logic ext_count_pin;
   logic match_toggle_pin;
   logic timer0_irq;
   logic timer1_irq;
   logic capture_irq;
   int fails, checks, cap_cnt, t1_cnt, n, hi, lo, k, d0;
   logic [7:0] r;
   logic [7:0] r2;
   int edge_exp[$] = '{3, 3, 6, 0};
   int tick[3] = '{PWM_CYC00, PWM_CYC01, PWM_CYC10};

   always #2.5 sys_clk = ~sys_clk;

   tccp_timer i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
      .external_irq_pin(external_irq_pin), .ext_count_pin(ext_count_pin),
      .match_toggle_pin(match_toggle_pin), .timer0_irq(timer0_irq),
      .timer1_irq(timer1_irq), .capture_irq(capture_irq));
   tccp_pin_partner i_pin (.sys_clk(sys_clk), .external_irq_pin(external_irq_pin),
      .ext_count_pin(ext_count_pin), .match_toggle_pin(match_toggle_pin));

   always @(posedge sys_clk) begin
      if (capture_irq === 1'b1) cap_cnt++;
      if (timer1_irq === 1'b1) t1_cnt++;
   end

   // Model: cycles from one match to the next
   function automatic int match_gap(input int data, input int div);
      return (data + 1) * div;
   endfunction : match_gap

   task automatic settle(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask : settle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   // Capture sampling may land one prescaled tick either side
   task automatic near(input logic [15:0] got, input int exp, input string what);
      checks++;
      if (got !== 16'(exp) && got !== 16'(exp - 1) && got !== 16'(exp + 1)) begin
         fails++;
         $display("[FAIL] %0t %s: got %h near %h", $time, what, got, exp);
      end
   endtask : near
   task automatic gap(input int sel, output int c);
      int g;
      g = 0;
      c = 0;
      while ((sel ? timer1_irq : timer0_irq) !== 1'b1 && g < 5000) begin
         settle(1);
         g++;
      end
      do begin
         settle(1);
         c++;
      end while ((sel ? timer1_irq : timer0_irq) !== 1'b1 && c < 5000);
   endtask : gap
   task automatic print_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (WATCH_CYC) @(posedge sys_clk);
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end

   initial begin
      fails = 0;
      checks = 0;
      cap_cnt = 0;
      t1_cnt = 0;
      bus = '0;
      arst_n = 1'b0;
      void'($urandom(32'heb34));
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd(ADDR_MODE1, r);
      chk(16'(r), 16'(RESET_BYTE), "mode reset");
      rd(4'hf, r);
      chk(16'(r), 16'h0000, "unmapped read");
      chk(16'(match_toggle_pin), 16'h0000, "pin idle");
      $display("test reset done");
      d0 = 1 + $urandom % 30;
      wr(ADDR_DATA0, 8'(d0));
      wr(ADDR_MODE0, 8'h00);
      gap(0, n);
      gap(0, n);
      chk(16'(n), 16'(match_gap(d0, 2)), "t0 match gap");
      wr(ADDR_DATA0, 8'h03);
      fork
         i_pin.ext_clocks(200, 5);
         begin
            wr(ADDR_MODE0, {5'h00, CLK_EXT_T0});
            gap(0, n);
            gap(0, n);
            chk(16'(n), 16'(match_gap(3, 10)), "ext count gap");
         end
      join
      wr(ADDR_MODE0, 8'h00);
      wr(ADDR_DATA0, 8'h02);
      wr(ADDR_DATA1, 8'h01);
      // PWM mode holds Timer 1 at zero, else the joined count may start above the match and wrap
      wr(ADDR_MODE1, 8'h10);
      wr(ADDR_MODE1, 8'h07);
      settle(4);
      t1_cnt = 0;
      gap(0, n);
      gap(0, n);
      chk(16'(n), 16'(match_gap(16'h0102, 2)), "joined gap");
      chk(16'(t1_cnt), 16'h0000, "no t1 irq joined");
      wr(ADDR_DATA0, 8'hff);
      wr(ADDR_DATA1, 8'hff);
      wr(ADDR_EDGE, {6'h00, EDGE_RISE});
      wr(ADDR_MODE0, 8'h08);
      i_pin.pulses(3, 600, 600);
      settle(10);
      rd(ADDR_DATA0, r);
      rd(ADDR_DATA1, r2);
      near({r2, r}, 1200 / 2, "16-bit snapshot");
      $display("test timers done");
      wr(ADDR_MODE1, 8'h00);
      for (k = 0; k < 4; k++) begin
         wr(ADDR_EDGE, 8'(k));
         settle(10);
         cap_cnt = 0;
         i_pin.pulses(3, 40, 60);
         settle(20);
         chk(16'(cap_cnt), 16'(edge_exp[k]), "capture edges");
         if (k == 1) begin
            rd(ADDR_DATA0, r);
            near(16'(r), 100 / 2, "8-bit snapshot");
         end
      end
      wr(ADDR_DATA0, 8'h77);
      rd(ADDR_DATA0, r);
      near(16'(r), 40 / 2, "snapshot after write");
      rd(ADDR_STATUS, r);
      chk(16'(r & 8'h04), 16'h0004, "capture flag");
      wr(ADDR_STATUS, 8'h04);
      rd(ADDR_STATUS, r);
      chk(16'(r & 8'h04), 16'h0000, "capture flag cleared");
      wr(ADDR_MODE0, 8'h00);
      wr(ADDR_MODE1, 8'h08);
      wr(ADDR_EDGE, {6'h00, EDGE_RISE});
      i_pin.pulses(3, 500, 500);
      settle(10);
      rd(ADDR_DATA1, r);
      near(16'(r), 1000 / PWM_CYC00, "t1 snapshot");
      $display("test capture done");
      wr(ADDR_MODE1, 8'h00);
      wr(ADDR_DATA1, 8'h03);
      wr(ADDR_PORTFN, 8'h01);
      i_pin.measure(hi, lo);
      chk(16'(hi), 16'(match_gap(3, PWM_CYC00)), "toggle high");
      chk(16'(lo), 16'(match_gap(3, PWM_CYC00)), "toggle low");
      gap(1, n);
      gap(1, n);
      chk(16'(n), 16'(match_gap(3, PWM_CYC00)), "t1 match gap");
      wr(ADDR_PORTFN, 8'h02);
      for (k = 0; k < 3; k++) begin
         wr(ADDR_MODE1, 8'h00);
         wr(ADDR_PERIOD, 8'h04);
         wr(ADDR_DUTY, 8'h01);
         wr(ADDR_HIGH, 8'h00);
         wr(ADDR_MODE1, 8'(8'h30 | k));
         i_pin.measure(hi, lo);
         chk(16'(hi), 16'(tick[k]), "pwm high");
         chk(16'(lo), 16'(3 * tick[k]), "pwm low");
      end
      wr(ADDR_MODE1, 8'h30);
      wr(ADDR_DUTY, 8'h03);
      i_pin.measure(hi, lo);
      chk(16'(hi), 16'(3 * PWM_CYC00), "new duty");
      wr(ADDR_PERIOD, 8'h08);
      i_pin.measure(hi, lo);
      chk(16'(hi), 16'(3 * PWM_CYC00), "abs duty");
      chk(16'(lo), 16'(5 * PWM_CYC00), "new period");
      wr(ADDR_MODE1, 8'h10);
      i_pin.measure(hi, lo);
      chk(16'(hi), 16'(5 * PWM_CYC00), "low polarity");
      wr(ADDR_MODE1, 8'h30);
      wr(ADDR_DUTY, 8'h08);
      settle(600);
      i_pin.run_len(1'b1, 400, n);
      chk(16'(n), 16'd400, "duty full");
      wr(ADDR_DUTY, 8'h00);
      settle(600);
      i_pin.run_len(1'b0, 400, n);
      chk(16'(n), 16'd400, "duty zero");
      wr(ADDR_MODE1, 8'h00);
      wr(ADDR_PERIOD, 8'h04);
      wr(ADDR_DUTY, 8'h02);
      wr(ADDR_HIGH, 8'h05);
      wr(ADDR_MODE1, 8'h30);
      i_pin.measure(hi, lo);
      chk(16'(hi), 16'(16'h102 * PWM_CYC00), "10-bit high");
      chk(16'(lo), 16'(2 * PWM_CYC00), "10-bit low");
      $display("test pwm done");
      print_verdict();
   end
endmodule : tccp_timer_tb_top
`default_nettype wire
